// file: verilog/rcpe_regs.sv
`timescale 1ns/1ps
`default_nettype none
// Notes on behaviour
// - Receive-ready mask bit 6 gates interrupt
// - Transmit-done mask bit 5 gates interrupt
// - Retry-limit mask bit 4 gates interrupt
// - CRC enable resets 1, forced by auto-ack
// - Bit 2 picks one or two CRC bytes
// - Bit 1 powers device up or down
// - Bit 0 selects receiver or transmitter role
// - Auto-ack bits 0..5 enable pipes 0..5
// - Auto-ack resets all ones, reserved zero
// - Receive enable bits gate pipe acceptance
// - Receive enables reset pipes 0,1 only
// - Flags set by event, cleared writing one
module rcpe_regs
  import rcpe_pkg::*;
#(
  parameter int PIPES = 6 // Data pipes served
)(
  input  wire logic       clk,
  input  wire logic       reset_n,
  input  wire logic       spi_sck,
  input  wire logic       spi_csn_n,
  input  wire logic       spi_mosi,
  output logic            spi_miso_o,
  output logic            spi_miso_oe,
  input  wire logic       rx_ready_event,
  input  wire logic       tx_done_event,
  input  wire logic       retry_limit_event,
  input  wire logic [2:0] rx_packet_pipe,
  input  wire logic       rx_packet_valid,
  output logic            rx_packet_accept,
  output logic            irq_n,
  output var  rcpe_cfg_t  cfg
);

  // ***************************************************************
  // Parameter check
  // ***************************************************************
  if (PIPES != 6)
  begin : g_bad_pipes
    $error("PIPES must be six");
  end

  // ***************************************************************
  // Serial port
  // ***************************************************************
  rcpe_spi_byte_t rx;      // Received byte stream
  logic [7:0]     tx_byte; // Next byte to send

  rcpe_spi_port #(
    .SYNC_STAGES (2)
  ) u_port (
    .clk     (clk),
    .reset_n (reset_n),
    .sck     (spi_sck),
    .csn_n   (spi_csn_n),
    .mosi    (spi_mosi),
    .tx_byte (tx_byte),
    .rx      (rx),
    .miso_o  (spi_miso_o),
    .miso_oe (spi_miso_oe)
  );

  // ***************************************************************
  // Command tracking
  // ***************************************************************
  logic       cmd_valid_q; // Command byte taken this frame
  logic [7:0] cmd_q;       // Command byte
  logic       data_seen_q; // First data byte already taken
  logic       wr_stb;      // Register write strobe
  logic [4:0] cmd_addr;    // Addressed register

  // Latch command, mark first data byte
  always_ff @(posedge clk)
  begin
    if (!reset_n)
    begin
      cmd_valid_q <= 1'b0;
      cmd_q       <= 8'h00;
      data_seen_q <= 1'b0;
    end
    else if (rx.frame_start)
    begin
      // Fresh frame
      cmd_valid_q <= 1'b0;
      data_seen_q <= 1'b0;
    end
    else if (rx.done)
    begin
      if (!cmd_valid_q)
      begin
        cmd_valid_q <= 1'b1;
        cmd_q       <= rx.data;
      end
      else
      begin
        data_seen_q <= 1'b1;
      end
    end
  end

  assign cmd_addr = cmd_q[4:0];
  // Only the first data byte after a write command stores
  assign wr_stb = rx.done && cmd_valid_q && !data_seen_q
                  && cmd_q[7:5] == RCPE_OP_WRITE;

  // Strobe for one register
  function automatic logic wr_hit(input logic stb,
                                  input logic [4:0] addr,
                                  input logic [4:0] off);
    wr_hit = stb && addr == off;
  endfunction

  // ***************************************************************
  // Configuration register
  // ***************************************************************
  logic rx_mask_q;  // Receive-ready mask
  logic tx_mask_q;  // Transmit-done mask
  logic rt_mask_q;  // Retry-limit mask
  logic crc_en_q;   // Stored CRC enable
  logic crc_len_q;  // CRC length select
  logic power_q;    // Power on bit
  logic role_q;     // Primary role select

  // Reserved bit 7 is not stored and reads zero
  always_ff @(posedge clk)
  begin
    if (!reset_n)
    begin
      rx_mask_q <= RCPE_RST_CONFIG[RCPE_BIT_RX_MASK];
      tx_mask_q <= RCPE_RST_CONFIG[RCPE_BIT_TX_MASK];
      rt_mask_q <= RCPE_RST_CONFIG[RCPE_BIT_RT_MASK];
      crc_en_q  <= RCPE_RST_CONFIG[RCPE_BIT_CRC_EN];
      crc_len_q <= RCPE_RST_CONFIG[RCPE_BIT_CRC_LEN];
      power_q   <= RCPE_RST_CONFIG[RCPE_BIT_POWER];
      role_q    <= RCPE_RST_CONFIG[RCPE_BIT_ROLE];
    end
    else if (wr_hit(wr_stb, cmd_addr, RCPE_OFF_CONFIG))
    begin
      rx_mask_q <= rx.data[RCPE_BIT_RX_MASK];
      tx_mask_q <= rx.data[RCPE_BIT_TX_MASK];
      rt_mask_q <= rx.data[RCPE_BIT_RT_MASK];
      crc_en_q  <= rx.data[RCPE_BIT_CRC_EN];
      crc_len_q <= rx.data[RCPE_BIT_CRC_LEN];
      power_q   <= rx.data[RCPE_BIT_POWER];
      role_q    <= rx.data[RCPE_BIT_ROLE];
    end
  end

  // ***************************************************************
  // Pipe enable registers
  // ***************************************************************
  logic [PIPES-1:0] auto_ack_q; // Auto-ack per pipe
  logic [PIPES-1:0] rx_pipe_q;  // Receive enable per pipe

  // Auto-ack enables, upper reserved bits dropped
  always_ff @(posedge clk)
  begin
    if (!reset_n)
    begin
      auto_ack_q <= RCPE_RST_AUTO_ACK;
    end
    else if (wr_hit(wr_stb, cmd_addr, RCPE_OFF_AUTO_ACK))
    begin
      auto_ack_q <= rx.data[PIPES-1:0];
    end
  end

  // Receive enables, upper reserved bits dropped
  always_ff @(posedge clk)
  begin
    if (!reset_n)
    begin
      rx_pipe_q <= RCPE_RST_RX_PIPE;
    end
    else if (wr_hit(wr_stb, cmd_addr, RCPE_OFF_RX_PIPE))
    begin
      rx_pipe_q <= rx.data[PIPES-1:0];
    end
  end

  // ***************************************************************
  // Event flags
  // ***************************************************************
  logic [2:0] flags_q;   // Receive, transmit, retry flags
  logic [2:0] flag_set;  // Incoming events
  logic [2:0] flag_clr;  // Write-one-to-clear bits

  assign flag_set = {rx_ready_event, tx_done_event, retry_limit_event};
  assign flag_clr = wr_hit(wr_stb, cmd_addr, RCPE_OFF_STATUS)
                    ? rx.data[RCPE_BIT_RX_FLAG:RCPE_BIT_RT_FLAG]
                    : 3'h0;

  // Set beats clear in the same cycle
  always_ff @(posedge clk)
  begin
    if (!reset_n)
    begin
      flags_q <= 3'h0;
    end
    else
    begin
      flags_q <= flag_set | (flags_q & ~flag_clr);
    end
  end

  // ***************************************************************
  // Interrupt pin
  // ***************************************************************
  // Active low while any unmasked flag stands
  always_ff @(posedge clk)
  begin
    if (!reset_n)
    begin
      irq_n <= 1'b1;
    end
    else
    begin
      irq_n <= !((flags_q[2] && !rx_mask_q)
              || (flags_q[1] && !tx_mask_q)
              || (flags_q[0] && !rt_mask_q));
    end
  end

  // ***************************************************************
  // Outputs to radio core
  // ***************************************************************
  logic crc_eff; // CRC enable as seen and read

  assign crc_eff = crc_en_q || (|auto_ack_q);

  // Registered configuration view
  always_ff @(posedge clk)
  begin
    if (!reset_n)
    begin
      cfg              <= '0;
      rx_packet_accept <= 1'b0;
    end
    else
    begin
      cfg.crc_enable          <= crc_eff;
      cfg.crc_length_select   <= crc_len_q;
      cfg.power_on_bit        <= power_q;
      cfg.primary_role_select <= role_q;
      cfg.auto_ack_pipe       <= auto_ack_q;
      cfg.rx_enable_pipe      <= rx_pipe_q;
      // Packet accepted only on an enabled pipe
      rx_packet_accept <= rx_packet_valid
                          && rx_packet_pipe < 3'(PIPES)
                          && rx_pipe_q[rx_packet_pipe];
    end
  end

  // ***************************************************************
  // Read data
  // ***************************************************************
  logic [7:0] status_byte; // Status as shifted out
  logic [7:0] rd_data;     // Addressed register

  assign status_byte = {1'b0, flags_q, RCPE_STATUS_LOW};

  // Reserved bits read zero; unmapped reads zero
  always_comb
  begin
    rd_data = 8'h00;
    case (cmd_addr)
      RCPE_OFF_CONFIG:
        rd_data = {1'b0, rx_mask_q, tx_mask_q, rt_mask_q,
                   crc_eff, crc_len_q, power_q, role_q};
      RCPE_OFF_AUTO_ACK:
        rd_data = {2'h0, auto_ack_q};
      RCPE_OFF_RX_PIPE:
        rd_data = {2'h0, rx_pipe_q};
      RCPE_OFF_STATUS:
        rd_data = status_byte;
      default:
        rd_data = 8'h00;
    endcase
  end

  // Status at frame open (old command may still be latched)
  always_comb
  begin
    if (!cmd_valid_q || !spi_miso_oe)
    begin
      tx_byte = status_byte;
    end
    else if (cmd_q[7:5] == RCPE_OP_READ)
    begin
      tx_byte = rd_data;
    end
    else
    begin
      tx_byte = 8'h00;
    end
  end

endmodule // rcpe_regs
`default_nettype wire

// file: verilog/rcpe_pkg.sv
`default_nettype none
package rcpe_pkg;

  // ***************************************************************
  // Register offsets
  // ***************************************************************
  localparam logic [4:0] RCPE_OFF_CONFIG   = 5'h00; // Radio configuration
  localparam logic [4:0] RCPE_OFF_AUTO_ACK = 5'h01; // Auto-ack pipe enables
  localparam logic [4:0] RCPE_OFF_RX_PIPE  = 5'h02; // Receive pipe enables
  localparam logic [4:0] RCPE_OFF_STATUS   = 5'h07; // Neighbouring status

  // ***************************************************************
  // Field positions, configuration register
  // ***************************************************************
  localparam int RCPE_BIT_RX_MASK   = 6; // Receive-ready mask
  localparam int RCPE_BIT_TX_MASK   = 5; // Transmit-done mask
  localparam int RCPE_BIT_RT_MASK   = 4; // Retry-limit mask
  localparam int RCPE_BIT_CRC_EN    = 3; // CRC enable
  localparam int RCPE_BIT_CRC_LEN   = 2; // CRC length select
  localparam int RCPE_BIT_POWER     = 1; // Power on bit
  localparam int RCPE_BIT_ROLE      = 0; // Primary role select

  // ***************************************************************
  // Field positions, status register
  // ***************************************************************
  localparam int RCPE_BIT_RX_FLAG   = 6; // Receive-ready flag
  localparam int RCPE_BIT_TX_FLAG   = 5; // Transmit-done flag
  localparam int RCPE_BIT_RT_FLAG   = 4; // Retry-limit flag
  localparam logic [3:0] RCPE_STATUS_LOW = 4'he; // Pipe none, fifo ok

  // ***************************************************************
  // Reset values
  // ***************************************************************
  localparam logic [7:0] RCPE_RST_CONFIG   = 8'h08; // CRC on only
  localparam logic [5:0] RCPE_RST_AUTO_ACK = 6'h3f; // All pipes ack
  localparam logic [5:0] RCPE_RST_RX_PIPE  = 6'h03; // Pipes 0 and 1

  // ***************************************************************
  // Command opcodes, upper three bits of the command byte
  // ***************************************************************
  localparam logic [2:0] RCPE_OP_READ  = 3'h0; // Read register
  localparam logic [2:0] RCPE_OP_WRITE = 3'h1; // Write register

  // ***************************************************************
  // Carriers
  // ***************************************************************
  // One received byte from the serial port
  typedef struct packed {
    logic       frame_start; // Chip select just fell
    logic       done;        // Eighth bit taken
    logic [7:0] data;        // Byte, MSB received first
  } rcpe_spi_byte_t;

  // Configuration seen by the radio core
  typedef struct packed {
    logic       crc_enable;          // Effective CRC enable
    logic       crc_length_select;   // 0 one byte, 1 two bytes
    logic       power_on_bit;        // 1 powered up
    logic       primary_role_select; // 1 receiver, 0 transmitter
    logic [5:0] auto_ack_pipe;       // Per-pipe auto-ack
    logic [5:0] rx_enable_pipe;      // Per-pipe receive enable
  } rcpe_cfg_t;

endpackage
`default_nettype wire

// file: verilog/rcpe_spi_port.sv
`timescale 1ns/1ps
`default_nettype none
module rcpe_spi_port
  import rcpe_pkg::*;
#(
  parameter int SYNC_STAGES = 2 // Synchroniser depth for pins
)(
  input  wire logic           clk,
  input  wire logic           reset_n,
  input  wire logic           sck,
  input  wire logic           csn_n,
  input  wire logic           mosi,
  input  wire logic [7:0]     tx_byte,
  output var  rcpe_spi_byte_t rx,
  output logic                miso_o,
  output logic                miso_oe
);

  // ***************************************************************
  // Parameter check
  // ***************************************************************
  if (SYNC_STAGES < 2)
  begin : g_bad_sync
    $error("SYNC_STAGES must be at least two");
  end

  // ***************************************************************
  // Pin synchronisers
  // ***************************************************************
  logic [SYNC_STAGES-1:0] sck_sync_q;  // Clock pin chain
  logic [SYNC_STAGES-1:0] csn_sync_q;  // Select pin chain
  logic [SYNC_STAGES-1:0] mosi_sync_q; // Data pin chain
  logic                   sck_prev_q;  // Last synced clock
  logic                   csn_prev_q;  // Last synced select
  logic                   sck_s;       // Synced clock
  logic                   csn_s;       // Synced select
  logic                   mosi_s;      // Synced data
  logic                   rise;        // Sampling edge
  logic                   fall;        // Shifting edge
  logic                   start;       // Frame opens

  // Shift pins in; only the last stage is read
  always_ff @(posedge clk)
  begin
    if (!reset_n)
    begin
      sck_sync_q  <= '0;
      csn_sync_q  <= '1;
      mosi_sync_q <= '0;
      sck_prev_q  <= 1'b0;
      csn_prev_q  <= 1'b1;
    end
    else
    begin
      sck_sync_q  <= {sck_sync_q[SYNC_STAGES-2:0], sck};
      csn_sync_q  <= {csn_sync_q[SYNC_STAGES-2:0], csn_n};
      mosi_sync_q <= {mosi_sync_q[SYNC_STAGES-2:0], mosi};
      sck_prev_q  <= sck_s;
      csn_prev_q  <= csn_s;
    end
  end

  assign sck_s  = sck_sync_q[SYNC_STAGES-1];
  assign csn_s  = csn_sync_q[SYNC_STAGES-1];
  assign mosi_s = mosi_sync_q[SYNC_STAGES-1];
  assign rise   = !csn_s && sck_s && !sck_prev_q;
  assign fall   = !csn_s && !sck_s && sck_prev_q;
  assign start  = !csn_s && csn_prev_q;

  // ***************************************************************
  // Receive shifter
  // ***************************************************************
  logic [2:0] bit_cnt_q;  // Bits taken in this byte
  logic [6:0] rx_sh_q;    // Partial byte
  logic       load_q;     // Reload transmit byte at next fall

  // Sample on rising edge, report whole bytes
  always_ff @(posedge clk)
  begin
    if (!reset_n)
    begin
      bit_cnt_q <= 3'h0;
      rx_sh_q   <= 7'h00;
      rx        <= '0;
    end
    else
    begin
      rx.frame_start <= start;
      rx.done        <= 1'b0;
      if (start)
      begin
        // New frame restarts byte alignment
        bit_cnt_q <= 3'h0;
      end
      else if (rise)
      begin
        rx_sh_q   <= {rx_sh_q[5:0], mosi_s};
        bit_cnt_q <= bit_cnt_q + 3'h1;
        if (bit_cnt_q == 3'h7)
        begin
          // Byte complete
          rx.done <= 1'b1;
          rx.data <= {rx_sh_q, mosi_s};
        end
      end
    end
  end

  // ***************************************************************
  // Transmit shifter
  // ***************************************************************
  logic [7:0] tx_sh_q; // Outgoing byte, MSB first

  // Load at frame start and after each byte, shift on fall
  always_ff @(posedge clk)
  begin
    if (!reset_n)
    begin
      tx_sh_q <= 8'h00;
      load_q  <= 1'b0;
      miso_o  <= 1'b0;
      miso_oe <= 1'b0;
    end
    else
    begin
      miso_oe <= !csn_s;
      miso_o  <= tx_sh_q[7];
      if (start)
      begin
        // First byte out is the status byte
        tx_sh_q <= tx_byte;
        load_q  <= 1'b0;
      end
      else if (rise && bit_cnt_q == 3'h7)
      begin
        // Wait for parent to decode before loading
        load_q <= 1'b1;
      end
      else if (fall)
      begin
        if (load_q)
        begin
          tx_sh_q <= tx_byte;
          load_q  <= 1'b0;
        end
        else
        begin
          tx_sh_q <= {tx_sh_q[6:0], 1'b0};
        end
      end
    end
  end

endmodule // rcpe_spi_port
`default_nettype wire

// file: dv/rcpe_regs_props.sv
`timescale 1ns/1ps
`default_nettype none
// ****************************************
// Port checker for the configuration bank
// ****************************************
module rcpe_regs_props
  import rcpe_pkg::*;
(
  input wire logic       clk,
  input wire logic       reset_n,
  input wire logic       spi_csn_n,
  input wire logic [2:0] rx_packet_pipe,
  input wire logic       rx_packet_valid,
  input wire logic       rx_packet_accept,
  input wire logic       irq_n,
  input wire rcpe_cfg_t  cfg
);
  logic [4:0] idle_q; // Quiet cycles on the port

  // Saturating count since chip select was last low
  always_ff @(posedge clk)
  begin
    if (!reset_n || !spi_csn_n)
      idle_q <= 5'h00;
    else if (idle_q != 5'h1f)
      idle_q <= idle_q + 5'h01;
  end

  default clocking dc @(posedge clk);
  endclocking
  default disable iff (!reset_n);

  chk_reset_config: assert property (
    $rose(reset_n) |-> ##2 (cfg.crc_enable && !cfg.crc_length_select
      && !cfg.power_on_bit && !cfg.primary_role_select))
    else $error("config fields wrong after reset");
  chk_reset_pipes: assert property (
    $rose(reset_n) |-> ##2 (cfg.auto_ack_pipe == 6'h3f
      && cfg.rx_enable_pipe == 6'h03))
    else $error("pipe enables wrong after reset");
  chk_crc_forced: assert property (
    (|cfg.auto_ack_pipe) |-> cfg.crc_enable)
    else $error("crc not forced by auto ack");
  chk_accept_on: assert property (
    (rx_packet_valid && rx_packet_pipe < 3'd6
      && cfg.rx_enable_pipe[rx_packet_pipe])
      ##1 $stable(cfg.rx_enable_pipe) |-> rx_packet_accept)
    else $error("enabled pipe not accepted");
  chk_accept_range: assert property (
    (rx_packet_valid && rx_packet_pipe >= 3'd6) |=> !rx_packet_accept)
    else $error("accept for pipe beyond five");
  chk_accept_idle: assert property (
    !rx_packet_valid |=> !rx_packet_accept)
    else $error("accept without candidate");
  chk_irq_holds: assert property (
    (!irq_n && idle_q > 5'd20) |=> !irq_n)
    else $error("interrupt released without host write");
  chk_cfg_quiet: assert property (
    (idle_q > 5'd20) |=> $stable(cfg))
    else $error("config changed without host write");

  // Main scenarios reached
  cov_accept: cover property (rx_packet_accept);
  cov_irq_set: cover property ($fell(irq_n));
  cov_irq_clear: cover property ($rose(irq_n));
endmodule // rcpe_regs_props

bind rcpe_regs rcpe_regs_props u_rcpe_regs_props (
  .clk              (clk),
  .reset_n          (reset_n),
  .spi_csn_n        (spi_csn_n),
  .rx_packet_pipe   (rx_packet_pipe),
  .rx_packet_valid  (rx_packet_valid),
  .rx_packet_accept (rx_packet_accept),
  .irq_n            (irq_n),
  .cfg              (cfg)
);
`default_nettype wire

// file: dv/rcpe_host_model.sv
`timescale 1ns/1ps
`default_nettype none
// ****************************************
// Host master on the serial port, mode 0
// ****************************************
module rcpe_host_model (
  input  wire logic clk,   // Core clock
  output logic      sck,   // Serial clock, 4 MHz
  output logic      csn_n, // Chip select
  output logic      mosi,  // Host data out
  input  wire logic miso   // Resolved device data
);
  logic busy; // Frame under way

  // Idle pins at time zero
  initial
  begin
    sck   = 1'b0;
    csn_n = 1'b1;
    mosi  = 1'b0;
    busy  = 1'b0;
  end

  // Data line carries no stale value between frames
  always @(posedge clk)
    if (!busy)
      mosi <= ~mosi;

  // One byte, MSB first; sample just before each rise
  task automatic shift(input logic [7:0] tx, output logic [7:0] rx);
    for (int i = 7; i >= 0; i--)
    begin
      mosi <= tx[i];
      repeat (5) @(posedge clk);
      @(negedge clk) rx[i] = miso;
      @(posedge clk) sck <= 1'b1;
      repeat (4) @(posedge clk);
      sck <= 1'b0;
    end
  endtask

  // Command byte then one data byte; settle time at both ends
  task automatic xfer(input logic [7:0] cmd, input logic [7:0] dat,
                      output logic [7:0] st, output logic [7:0] rd);
    busy = 1'b1;
    @(posedge clk) csn_n <= 1'b0;
    repeat (8) @(posedge clk);
    shift(cmd, st);
    shift(dat, rd);
    repeat (4) @(posedge clk);
    csn_n <= 1'b1;
    repeat (6) @(posedge clk);
    busy = 1'b0;
  endtask
endmodule // rcpe_host_model
`default_nettype wire

// file: dv/tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module tb_top
  import rcpe_pkg::*;
;
  logic       clk;       // Core clock
  logic       reset_n;   // Sync reset
  logic       sck;       // Serial clock
  logic       csn_n;     // Chip select
  logic       mosi;      // Host data
  logic       miso_o;    // Device data
  logic       miso_oe;   // Device drive enable
  wire logic  miso_line; // Resolved data line
  logic [2:0] ev;        // Events: retry, tx, rx
  logic [2:0] pipe;      // Candidate pipe
  logic       valid;     // Candidate present
  logic       accept;    // Pipe accepted
  logic       irq_n;     // Interrupt pin
  rcpe_cfg_t  cfg;       // Core configuration
  logic [31:0] seed;     // Random state
  int         error_cnt; // Mismatches
  int         n_tests;   // Comparisons

  // Line pulled high when the device lets go
  assign miso_line = miso_oe ? miso_o : 1'b1;

  initial clk = 1'b0;
  always #12.5 clk = ~clk;

  rcpe_regs u_rcpe_regs (
    .clk               (clk),
    .reset_n           (reset_n),
    .spi_sck           (sck),
    .spi_csn_n         (csn_n),
    .spi_mosi          (mosi),
    .spi_miso_o        (miso_o),
    .spi_miso_oe       (miso_oe),
    .rx_ready_event    (ev[2]),
    .tx_done_event     (ev[1]),
    .retry_limit_event (ev[0]),
    .rx_packet_pipe    (pipe),
    .rx_packet_valid   (valid),
    .rx_packet_accept  (accept),
    .irq_n             (irq_n),
    .cfg               (cfg)
  );

  rcpe_host_model u_rcpe_host_model (
    .clk   (clk),
    .sck   (sck),
    .csn_n (csn_n),
    .mosi  (mosi),
    .miso  (miso_line)
  );

  // ****************************************
  // Helpers
  // ****************************************
  function automatic logic [31:0] lfsr_next(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  // Config readback: CRC shows forced while any auto-ack is set
  function automatic logic [7:0] exp_config(input logic [7:0] c,
                                            input logic [5:0] aa);
    return c | {4'h0, |aa, 3'h0};
  endfunction

  task automatic chk(input string name, input logic [31:0] exp,
                     input logic [31:0] got);
    n_tests++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("wrong value %s expected %h seen %h", name, exp, got);
    end
  endtask

  task automatic wr(input logic [4:0] a, input logic [7:0] v);
    logic [7:0] st;
    logic [7:0] rd;
    u_rcpe_host_model.xfer({RCPE_OP_WRITE, a}, v, st, rd);
  endtask

  task automatic rd(input string name, input logic [4:0] a,
                    input logic [7:0] exp);
    logic [7:0] st;
    logic [7:0] got;
    u_rcpe_host_model.xfer({RCPE_OP_READ, a}, 8'h00, st, got);
    chk(name, {24'h0, exp}, {24'h0, got});
    if (a == RCPE_OFF_STATUS)
      chk("status_byte", {24'h0, exp}, {24'h0, st});
  endtask

  task automatic summarize();
    $display("comparisons %0d mismatches %0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  // Cut a hang at about four times the expected run
  initial
  begin
    repeat (40000) @(posedge clk);
    error_cnt++;
    summarize();
  end

  // ****************************************
  // Main sequence
  // ****************************************
  initial
  begin
    logic [7:0] c;
    logic [5:0] aa;
    logic [5:0] rx;
    reset_n = 1'b0;
    ev = 3'h0;
    pipe = 3'h0;
    valid = 1'b0;
    error_cnt = 0;
    n_tests = 0;
    seed = 32'h8330;
    repeat (5) @(posedge clk);
    reset_n <= 1'b1;
    repeat (3) @(posedge clk);
    rd("config", RCPE_OFF_CONFIG, 8'h08);
    rd("auto_ack", RCPE_OFF_AUTO_ACK, 8'h3f);
    rd("rx_pipe", RCPE_OFF_RX_PIPE, 8'h03);
    rd("status", RCPE_OFF_STATUS, 8'h0e);
    wr(RCPE_OFF_AUTO_ACK, 8'h00);
    rd("crc_reset", RCPE_OFF_CONFIG, 8'h08);
    $display("test reset_values done");
    // Random settings; first pass without auto-ack
    for (int k = 0; k < 4; k++)
    begin
      seed = lfsr_next(seed);
      aa = (k == 0) ? 6'h00 : seed[5:0];
      c = seed[15:8] & 8'h7f;
      rx = seed[21:16];
      wr(RCPE_OFF_AUTO_ACK, {2'b00, aa});
      wr(RCPE_OFF_CONFIG, c);
      wr(RCPE_OFF_RX_PIPE, {2'b00, rx});
      rd("auto_ack", RCPE_OFF_AUTO_ACK, {2'b00, aa});
      rd("config", RCPE_OFF_CONFIG, exp_config(c, aa));
      rd("rx_pipe", RCPE_OFF_RX_PIPE, {2'b00, rx});
      chk("cfg", {16'h0, |aa | c[3], c[2:0], aa, rx}, {16'h0, cfg});
      // Every pipe number, two beyond the last
      for (int p = 0; p < 8; p++)
      begin
        @(posedge clk);
        pipe <= 3'(p);
        valid <= 1'b1;
        @(posedge clk);
        valid <= 1'b0;
        @(negedge clk);
        chk("accept", {31'h0, p < 6 && rx[p]}, {31'h0, accept});
      end
    end
    wr(5'h03, 8'h5a);
    rd("unmapped", 5'h03, 8'h00);
    $display("test random_config done");
    // Each event, unmasked then masked
    for (int i = 0; i < 6; i++)
    begin
      wr(RCPE_OFF_CONFIG, 8'(i % 2) << (4 + i / 2));
      @(posedge clk);
      ev[i / 2] <= 1'b1;
      @(posedge clk);
      ev <= 3'h0;
      repeat (3) @(posedge clk);
      @(negedge clk);
      chk("irq_n", {31'h0, 1'(i % 2)}, {31'h0, irq_n});
      rd("status", RCPE_OFF_STATUS, 8'h0e | 8'(1 << (4 + i / 2)));
      if (i % 2 == 1)
      begin
        wr(RCPE_OFF_CONFIG, 8'h00);
        @(negedge clk);
        chk("irq_unmask", 32'h0, {31'h0, irq_n});
      end
      wr(RCPE_OFF_STATUS, 8'(1 << (4 + i / 2)));
      @(negedge clk);
      chk("irq_clear", 32'h1, {31'h0, irq_n});
      rd("status", RCPE_OFF_STATUS, 8'h0e);
    end
    $display("test irq_events done");
    summarize();
  end
endmodule // tb_top
`default_nettype wire
